/* File: rtl/shbbp_pkg.sv */
package shbbp_pkg;
  localparam int SHB_W = 8;
  localparam int PC_W = 11;
  localparam int OUT_FIFO_DEPTH = 16;
  localparam int SYNC_W = 13;
  // status register bit positions
  localparam int OBF_BIT = 0;
  localparam int IBF_BIT = 1;
  localparam int F0_BIT = 2;
  localparam int F1_BIT = 3;
  localparam int FW_LSB = 4;
  localparam int FW_MSB = 7;
  // address input selects
  localparam logic A0_DATA = 1'b0;
  localparam logic A0_STATUS = 1'b1;
  // reset values
  localparam logic [SHB_W-1:0] BUF_RST = 8'h00;
  localparam logic [3:0] FW_BITS_RST = 4'h0;
  // call target of an accepted external interrupt
  localparam logic [PC_W-1:0] EXT_INT_VECTOR = 11'h003;
  typedef enum logic {INT_IDLE, INT_SERVICE} shbbp_int_t;
endpackage

/* File: rtl/shbbp_fifo.sv */
`timescale 1ns/1ps
module shbbp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;

  assign in_ready_o = (count != FULL_CNT);
  assign out_valid_o = (count != '0);
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem[rd_ptr];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // pointers wrap through the full range, so depth must be a power of two
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // shbbp_fifo

/* File: rtl/shbbp_port.sv */
`timescale 1ns/1ps
// Function
// - address input picks data buffers or status
// - drive buffer or status on read, else float
// - host write copies address level into flag one
// - eight-bit status, upper nibble firmware loaded
// - output-full set by output instr, cleared by data read
// - input-full set by host write, cleared by input
// - firmware complements or clears user flag zero
// - firmware also complements or clears flag one
// - output instruction moves accumulator to out buffer
// - selected write strobe latches bus byte inbound
// - select and write low raise external interrupt
// - firmware jumps test input-full, output-full, test pins
// - host bus runs asynchronous to device clock
// - reset clears user flags, interrupts disabled
// - accepted external interrupt calls address three
module shbbp_port
  import shbbp_pkg::*;
#(
  parameter int FIFO_DEPTH = OUT_FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic a0_i,
  input wire logic [shbbp_pkg::SHB_W-1:0] data_i,
  output logic [shbbp_pkg::SHB_W-1:0] data_o,
  output logic data_oe_n_o,
  input wire logic t0_i,
  input wire logic t1_i,
  input wire logic [shbbp_pkg::SHB_W-1:0] fw_acc_i,
  input wire logic fw_out_i,
  output logic fw_out_ready_o,
  input wire logic fw_in_i,
  output logic [shbbp_pkg::SHB_W-1:0] fw_in_data_o,
  input wire logic fw_mov_sts_i,
  input wire logic fw_f0_cpl_i,
  input wire logic fw_f0_clr_i,
  input wire logic fw_f1_cpl_i,
  input wire logic fw_f1_clr_i,
  input wire logic fw_eint_en_i,
  input wire logic fw_eint_dis_i,
  input wire logic fw_tint_en_i,
  input wire logic fw_tint_dis_i,
  input wire logic fw_retr_i,
  output logic jc_ibf_o,
  output logic jc_obf_o,
  output logic jc_t0_o,
  output logic jc_t1_o,
  output logic eint_en_o,
  output logic tint_en_o,
  output logic int_call_o,
  output logic [shbbp_pkg::PC_W-1:0] int_vector_o
);
  import shbbp_pkg::*;

  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic cs_s, rd_s, wr_s, a0_s, t0_s, t1_s;
  logic [SHB_W-1:0] data_s;
  logic wr_act, wr_act_q, wr_done;
  logic rd_act, rd_act_q, rd_done;
  logic [SHB_W-1:0] wr_data_q;
  logic wr_a0_q, rd_a0_q;
  logic [SHB_W-1:0] outbuf, inbuf;
  logic output_full_flag, input_full_flag, f0, f1;
  logic [3:0] fw_bits;
  logic [SHB_W-1:0] status;
  logic fifo_valid, fifo_take;
  logic [SHB_W-1:0] fifo_data;
  logic eint_pend, eint_en, tint_en;
  shbbp_int_t int_state;
  logic take_int;

  // every host pin crosses two flops before use
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_a <= {4'hF, 9'h000};
      sync_b <= {4'hF, 9'h000};
    end else begin
      sync_a <= {cs_n_i, rd_n_i, wr_n_i, a0_i, t0_i, t1_i, 7'h00};
      sync_b <= sync_a;
    end
  end
  // data shares the same two stages
  logic [SHB_W-1:0] data_a;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_a <= BUF_RST;
      data_s <= BUF_RST;
    end else begin
      data_a <= data_i;
      data_s <= data_a;
    end
  end
  assign cs_s = sync_b[12];
  assign rd_s = sync_b[11];
  assign wr_s = sync_b[10];
  assign a0_s = sync_b[9];
  assign t0_s = sync_b[8];
  assign t1_s = sync_b[7];

  // write wins nothing over read: the master keeps them apart
  assign wr_act = ~cs_s & ~wr_s & rd_s;
  assign rd_act = ~cs_s & ~rd_s & wr_s;
  assign wr_done = wr_act_q & ~wr_act;
  assign rd_done = rd_act_q & ~rd_act;

  // byte and address are resampled every cycle while the strobe is low, and the last sample used at its end
  // so a slow-settling bus is never sampled mid-change
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
      wr_data_q <= BUF_RST;
      wr_a0_q <= A0_DATA;
      rd_a0_q <= A0_DATA;
    end else begin
      wr_act_q <= wr_act;
      rd_act_q <= rd_act;
      if (wr_act) begin
        wr_data_q <= data_s;
        wr_a0_q <= a0_s;
      end
      if (rd_act) begin
        rd_a0_q <= a0_s;
      end
    end
  end

  // inbound buffer
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      inbuf <= BUF_RST;
    end else if (wr_done) begin
      inbuf <= wr_data_q;
    end
  end
  assign fw_in_data_o = inbuf;

  // input-full: a host write in the same cycle as the firmware read wins
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      input_full_flag <= 1'b0;
    end else if (wr_done) begin
      input_full_flag <= 1'b1;
    end else if (fw_in_i) begin
      input_full_flag <= 1'b0;
    end
  end

  // outbound path: firmware pushes, buffer reloads only once drained
  shbbp_fifo #(
    .WIDTH(SHB_W),
    .DEPTH(FIFO_DEPTH)
  ) u_out_fifo (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(fw_out_i),
    .in_ready_o(fw_out_ready_o),
    .in_data_i(fw_acc_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_take),
    .out_data_o(fifo_data)
  );
  // never reload while a data read is in flight
  assign fifo_take = fifo_valid & ~output_full_flag & ~(rd_act & (a0_s == A0_DATA));

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      outbuf <= BUF_RST;
    end else if (fifo_take) begin
      outbuf <= fifo_data;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      output_full_flag <= 1'b0;
    end else if (fifo_take) begin
      output_full_flag <= 1'b1;
    end else if (rd_done && rd_a0_q == A0_DATA) begin
      output_full_flag <= 1'b0;
    end
  end

  // user flags; the host write load of flag one wins over firmware
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      f0 <= 1'b0;
    end else if (fw_f0_clr_i) begin
      f0 <= 1'b0;
    end else if (fw_f0_cpl_i) begin
      f0 <= ~f0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      f1 <= 1'b0;
    end else if (wr_done) begin
      f1 <= wr_a0_q;
    end else if (fw_f1_clr_i) begin
      f1 <= 1'b0;
    end else if (fw_f1_cpl_i) begin
      f1 <= ~f1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fw_bits <= FW_BITS_RST;
    end else if (fw_mov_sts_i) begin
      fw_bits <= fw_acc_i[FW_MSB:FW_LSB];
    end
  end

  assign status = {fw_bits, f1, f0, input_full_flag, output_full_flag};

  // read data comes from a flop; the enable follows the strobe directly
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_o <= BUF_RST;
    end else if (a0_s == A0_STATUS) begin
      data_o <= status;
    end else begin
      data_o <= outbuf;
    end
  end
  assign data_oe_n_o = ~rd_act;

  assign jc_ibf_o = input_full_flag;
  assign jc_obf_o = output_full_flag;
  assign jc_t0_o = t0_s;
  assign jc_t1_o = t1_s;

  // interrupt enables and single-level external interrupt
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      eint_en <= 1'b0;
      tint_en <= 1'b0;
    end else begin
      if (fw_eint_dis_i) begin
        eint_en <= 1'b0;
      end else if (fw_eint_en_i) begin
        eint_en <= 1'b1;
      end
      if (fw_tint_dis_i) begin
        tint_en <= 1'b0;
      end else if (fw_tint_en_i) begin
        tint_en <= 1'b1;
      end
    end
  end
  assign eint_en_o = eint_en;
  assign tint_en_o = tint_en;

  assign take_int = (int_state == INT_IDLE) & eint_pend & eint_en;

  // pending stays set while a new write lands in the call cycle
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      eint_pend <= 1'b0;
    end else if (wr_done) begin
      eint_pend <= 1'b1;
    end else if (take_int) begin
      eint_pend <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      int_state <= INT_IDLE;
    end else begin
      case (int_state)
        INT_IDLE: begin
          if (take_int) begin
            int_state <= INT_SERVICE;
          end
        end
        INT_SERVICE: begin
          if (fw_retr_i) begin
            int_state <= INT_IDLE;
          end
        end
        default: int_state <= INT_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      int_call_o <= 1'b0;
      int_vector_o <= '0;
    end else begin
      int_call_o <= take_int;
      int_vector_o <= EXT_INT_VECTOR;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  AST_FLOAT_UNLESS_READ: assert property (
    cs_s |-> data_oe_n_o)
    else $error("bus driven while not selected");
  AST_READ_DATA: assert property (
    (rd_act && a0_s == A0_DATA && !fifo_take) ##1 rd_act
      |-> data_o == $past(outbuf))
    else $error("data read does not show outbound buffer");
  AST_WRITE_LATCH: assert property (
    wr_done |=> inbuf == $past(wr_data_q) && input_full_flag)
    else $error("host write not latched");
  AST_F1_FROM_A0: assert property (
    wr_done |=> f1 == $past(wr_a0_q))
    else $error("flag one not loaded from address");
  AST_READ_CLEARS_OBF: assert property (
    (rd_done && rd_a0_q == A0_DATA && !fifo_take) |=> !output_full_flag)
    else $error("output-full not cleared by host read");
  AST_FW_IN_CLEARS_IBF: assert property (
    (fw_in_i && !wr_done) |=> !input_full_flag)
    else $error("input-full not cleared by firmware");
  AST_MOV_STS: assert property (
    fw_mov_sts_i |=> status[FW_MSB:FW_LSB] == $past(fw_acc_i[FW_MSB:FW_LSB]))
    else $error("firmware status bits not loaded");
  AST_OUT_LOAD: assert property (
    (fw_out_i && !fifo_valid && !output_full_flag && !rd_act)
      |=> ##[0:2] (output_full_flag && outbuf == $past(fw_acc_i, 2)))
    else $error("accumulator not moved to outbound buffer");
  AST_F0_CPL: assert property (
    (fw_f0_cpl_i && !fw_f0_clr_i) |=> f0 != $past(f0))
    else $error("flag zero not complemented");
  AST_INT_CALL: assert property (
    (eint_pend && eint_en && int_state == INT_IDLE)
      |=> int_call_o && int_vector_o == EXT_INT_VECTOR)
    else $error("external interrupt call missing");
  AST_WRITE_PENDS: assert property (
    wr_done |=> eint_pend || int_call_o)
    else $error("host write did not raise interrupt");

  COV_CMD_WRITE: cover property (wr_done && wr_a0_q == A0_STATUS);
  COV_DATA_READ: cover property (rd_done && rd_a0_q == A0_DATA && output_full_flag);
  COV_INT_CALL: cover property (int_call_o);
  COV_FIFO_FULL: cover property (!fw_out_ready_o);
endmodule // shbbp_port

/* File: verification/shbbp_host_model.sv */
`timescale 1ns/1ps
module shbbp_host_model (
  input wire logic clk_i,
  input wire logic [shbbp_pkg::SHB_W-1:0] dev_data_i,
  input wire logic dev_oe_n_i,
  output logic cs_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic a0_o,
  output logic [shbbp_pkg::SHB_W-1:0] bus_o,
  output logic rd_evt_o,
  output logic [shbbp_pkg::SHB_W-1:0] rd_byte_o
);
  import shbbp_pkg::*;
  logic drv;
  logic [SHB_W-1:0] wdat;
  logic [SHB_W-1:0] last;

  initial begin
    cs_n_o = 1'h1;
    rd_n_o = 1'h1;
    wr_n_o = 1'h1;
    a0_o = 1'h0;
    drv = 1'h0;
    wdat = 8'h00;
    last = 8'h00;
    rd_evt_o = 1'h0;
    rd_byte_o = 8'h00;
  end

  // no pull on the bus: a floating bus shows the complement of its last value, changing every clock
  always_comb begin
    if (drv) begin
      bus_o = wdat;
    end else if (dev_oe_n_i === 1'h0) begin
      bus_o = dev_data_i;
    end else begin
      bus_o = ~last;
    end
  end

  always @(posedge clk_i) begin
    last <= bus_o;
  end

  // pins move only on the falling edge of the device clock
  task automatic access(input logic rd, input logic a,
                        input logic [SHB_W-1:0] d, input int n,
                        output logic [SHB_W-1:0] q);
    @(negedge clk_i);
    a0_o = a;
    wdat = d;
    drv = !rd;
    cs_n_o = 1'h0;
    rd_n_o = !rd;
    wr_n_o = rd;
    repeat (n) @(negedge clk_i);
    q = bus_o;
    cs_n_o = 1'h1;
    rd_n_o = 1'h1;
    wr_n_o = 1'h1;
    // data and address outlive the strobe so the synchronizer sees them
    repeat (2) @(negedge clk_i);
    drv = 1'h0;
    repeat (2) @(negedge clk_i);
  endtask

  task automatic host_write(input logic a, input logic [SHB_W-1:0] d,
                            input int n);
    logic [SHB_W-1:0] q;
    access(1'h0, a, d, n, q);
  endtask

  task automatic host_read(input logic a, input int n);
    logic [SHB_W-1:0] q;
    access(1'h1, a, 8'h00, n, q);
    rd_byte_o = q;
    rd_evt_o = 1'h1;
    @(negedge clk_i);
    rd_evt_o = 1'h0;
  endtask

  task automatic poll_obf(output logic ok);
    logic [SHB_W-1:0] q;
    ok = 1'h0;
    for (int i = 0; i < 20 && !ok; i++) begin
      access(1'h1, A0_STATUS, 8'h00, 4, q);
      ok = (q[OBF_BIT] === 1'h1);
    end
  endtask

  // deliberate protocol breach, used only by the refusal scenario
  task automatic host_both(input int n);
    @(negedge clk_i);
    cs_n_o = 1'h0;
    rd_n_o = 1'h0;
    wr_n_o = 1'h0;
    repeat (n) @(negedge clk_i);
    cs_n_o = 1'h1;
    rd_n_o = 1'h1;
    wr_n_o = 1'h1;
    repeat (4) @(negedge clk_i);
  endtask
endmodule // shbbp_host_model

/* File: verification/tb.sv */
`timescale 1ns/1ps
module tb;
  import shbbp_pkg::*;
  logic clk_i = 1'h0;
  logic rstn_i = 1'h0;
  logic cs_n, rd_n, wr_n, a0, oe_n, rd_evt, ordy, jibf, jobf, jt0, jt1;
  logic een, ten, icall, ok;
  logic t0 = 1'h0;
  logic t1 = 1'h0;
  logic [7:0] bus, dout, rd_byte, fin, d;
  logic [7:0] acc = 8'h00;
  logic [11:0] fwp = 12'h000;
  logic [PC_W-1:0] ivec;
  logic [7:0] expq[$];
  logic [7:0] pushed[$];
  int err_total = 0;
  int comparisons = 0;
  int calls = 0;
  int n;
  int ops[5] = '{6, 5, 3, 4, 6};
  logic [7:0] fx[5] = '{8'h00, 8'h08, 8'h0c, 8'h08, 8'h00};

  always #25 clk_i = ~clk_i;

  shbbp_port #(.FIFO_DEPTH(OUT_FIFO_DEPTH)) dut_u (
    .clk_i(clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .a0_i(a0), .data_i(bus), .data_o(dout),
    .data_oe_n_o(oe_n), .t0_i(t0), .t1_i(t1), .fw_acc_i(acc),
    .fw_out_i(fwp[0]), .fw_out_ready_o(ordy), .fw_in_i(fwp[1]),
    .fw_in_data_o(fin), .fw_mov_sts_i(fwp[2]), .fw_f0_cpl_i(fwp[3]),
    .fw_f0_clr_i(fwp[4]), .fw_f1_cpl_i(fwp[5]), .fw_f1_clr_i(fwp[6]),
    .fw_eint_en_i(fwp[7]), .fw_eint_dis_i(fwp[8]),
    .fw_tint_en_i(fwp[9]), .fw_tint_dis_i(fwp[10]), .fw_retr_i(fwp[11]),
    .jc_ibf_o(jibf), .jc_obf_o(jobf), .jc_t0_o(jt0), .jc_t1_o(jt1),
    .eint_en_o(een), .tint_en_o(ten), .int_call_o(icall),
    .int_vector_o(ivec));

  shbbp_host_model host_u (
    .clk_i(clk_i), .dev_data_i(dout), .dev_oe_n_i(oe_n), .cs_n_o(cs_n),
    .rd_n_o(rd_n), .wr_n_o(wr_n), .a0_o(a0), .bus_o(bus),
    .rd_evt_o(rd_evt), .rd_byte_o(rd_byte));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic rd(input logic a, input logic [7:0] e);
    expq.push_back(e);
    host_u.host_read(a, 4 + $urandom_range(4));
  endtask

  task automatic pulse(input int k);
    @(negedge clk_i);
    fwp[k] = 1'h1;
    @(negedge clk_i);
    fwp[k] = 1'h0;
    repeat (2) @(negedge clk_i);
  endtask

  always @(posedge clk_i) begin
    if (icall === 1'h1) begin
      calls++;
    end
    if (rd_evt === 1'h1) begin
      if (expq.size() == 0) begin
        check(rd_byte, ~rd_byte);
      end else begin
        check(rd_byte, expq.pop_front());
      end
    end
  end

  initial begin
    #(50 * 40000);
    err_total++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'h9a3f));
    repeat (2) @(negedge clk_i);
    rstn_i = 1'h1;
    repeat (3) @(negedge clk_i);
    check(een, 1'h0);
    check(ten, 1'h0);
    check(ivec[7:0], 8'h03);
    check(oe_n, 1'h1);
    rd(A0_STATUS, 8'h00);
    for (int i = 0; i < 2; i++) begin
      d = 8'($urandom);
      host_u.host_write(i[0], d, 3 + i * 5);
      check(fin, d);
      check(jibf, 1'h1);
      rd(A0_STATUS, {4'h0, i[0], 3'h2});
      pulse(1);
      rd(A0_STATUS, {4'h0, i[0], 3'h0});
    end
    for (int i = 0; i < 5; i++) begin
      pulse(ops[i]);
      rd(A0_STATUS, fx[i]);
    end
    acc = 8'($urandom);
    pulse(2);
    rd(A0_STATUS, {acc[7:4], 4'h0});
    acc = 8'h00;
    pulse(2);
    rd(A0_STATUS, 8'h00);
    // both strobes at once must leave every flag alone
    host_u.host_both(4);
    rd(A0_STATUS, 8'h00);
    n = 0;
    @(negedge clk_i);
    while (ordy === 1'h1 && n < 40) begin
      acc = 8'($urandom);
      pushed.push_back(acc);
      fwp[0] = 1'h1;
      n++;
      @(negedge clk_i);
    end
    fwp[0] = 1'h0;
    // sixteen in the queue plus one already in the outbound buffer
    check(n[7:0], 8'h11);
    check(jobf, 1'h1);
    while (pushed.size() > 0) begin
      host_u.poll_obf(ok);
      check(ok, 1'h1);
      rd(A0_DATA, pushed.pop_front());
    end
    rd(A0_STATUS, 8'h00);
    check(jobf, 1'h0);
    for (int i = 0; i < 2; i++) begin
      t0 = i[0];
      t1 = !i[0];
      repeat (4) @(negedge clk_i);
      check(jt0, i[0]);
      check(jt1, !i[0]);
    end
    pulse(9);
    check(ten, 1'h1);
    pulse(10);
    check(ten, 1'h0);
    calls = 0;
    pulse(7);
    check(een, 1'h1);
    // writes made while disabled stay pending and are taken once enabled
    check(calls[7:0], 8'h01);
    pulse(11);
    calls = 0;
    host_u.host_write(A0_DATA, 8'h3c, 4);
    for (int i = 0; i < 20 && calls == 0; i++) @(negedge clk_i);
    check(calls[7:0], 8'h01);
    check(ivec[7:0], 8'h03);
    check(jibf, 1'h1);
    // only one level: a second request waits for the return
    host_u.host_write(A0_STATUS, 8'hc3, 4);
    repeat (10) @(negedge clk_i);
    check(calls[7:0], 8'h01);
    pulse(11);
    repeat (6) @(negedge clk_i);
    check(calls[7:0], 8'h02);
    pulse(11);
    pulse(8);
    check(een, 1'h0);
    tally_and_finish();
  end
endmodule // tb
